// File: hdl/bpsm_pkg.sv
`default_nettype none
package bpsm_pkg;
  // clock and oscillator
  localparam int CLK_KHZ        = 50000;
  localparam int OSC_KHZ        = 1600;
  localparam int OSC_DIV_CYC    = CLK_KHZ / OSC_KHZ;
  localparam int SHORT_SLOW_DIV = 3;
  // delays in microseconds and in oscillator ticks
  localparam int POR_DELAY_US   = 1000;
  localparam int POR_TICKS      = POR_DELAY_US * OSC_KHZ / 1000;
  localparam int WAKE_US        = 600;
  localparam int WAKE_TICKS     = WAKE_US * OSC_KHZ / 1000;
  localparam int SS_US          = 1100;
  localparam int SS_STEPS       = 256;
  localparam int SS_STEP_TICKS  = SS_US * OSC_KHZ / 1000 / SS_STEPS;
  // light-load entry
  localparam int ZC_ENTER_CNT   = 8;
  // apb map
  localparam logic [7:0] CTRL_OFF   = 8'h00;
  localparam logic [7:0] STATUS_OFF = 8'h04;
  localparam logic [7:0] ZCNT_OFF   = 8'h08;
  localparam int CTRL_SKIP_EN_BIT   = 0;
  localparam logic CTRL_SKIP_EN_RST = 1'b1;
  localparam int ST_STATE_LSB       = 0;
  localparam int ST_SKIP_BIT        = 2;
  localparam int ST_IDLE_BIT        = 3;
  localparam int ST_HS_BIT          = 4;
  localparam int ST_LS_BIT          = 5;
  localparam int ST_RESET_OUT_BIT   = 6;
  localparam int ST_SHORT_BIT       = 7;

  typedef enum logic [1:0] {
    ST_OFF  = 2'b00,
    ST_WAKE = 2'b01,
    ST_SOFT = 2'b11,
    ST_RUN  = 2'b10
  } bpsm_state_t;

  typedef struct packed {
    logic enable;
    logic skip_sel;
    logic timer_restart_in;
    logic ramp_trip;
    logic skip_trip;
    logic zero_cross;
    logic out_high;
    logic out_low;
    logic overcurrent_detector;
    logic output_short_detector;
    logic low_supply_lockout;
    logic over_temp;
    logic output_in_window;
  } bpsm_flags_t;

  localparam int FLAGS_W = $bits(bpsm_flags_t);
endpackage
`default_nettype wire

// File: hdl/bpsm_sync.sv
`timescale 1ns/1ps
`default_nettype none
module bpsm_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // async in, synced out
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_r;

  generate
    if (W < 1) begin : g_chk
      $error("bpsm_sync width must be at least 1");
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r   <= '0;
      sync_out <= '0;
    end else begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule
`default_nettype wire

// File: hdl/bpsm_por_timer.sv
`timescale 1ns/1ps
`default_nettype none
module bpsm_por_timer #(
  parameter int TICKS = 1600
) (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // oscillator tick and arm level
  input  wire logic tick,
  input  wire logic arm,
  // delay elapsed
  output logic      done
);
  localparam int CW = $clog2(TICKS + 1);
  logic [CW-1:0] cnt_r;

  generate
    if (TICKS < 1) begin : g_chk
      $error("bpsm_por_timer needs at least one tick");
    end
  endgenerate

  // RULE_22: restart on disarm
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= '0;
    end else if (!arm) begin
      cnt_r <= '0;
    end else if (tick && (cnt_r != CW'(TICKS))) begin
      cnt_r <= cnt_r + CW'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done <= 1'b0;
    end else begin
      done <= arm && (cnt_r == CW'(TICKS));
    end
  end
endmodule
`default_nettype wire

// File: hdl/bpsm_ctrl.sv
// What this block does
// RULE_01: switching cycles come from a fixed oscillator, nominally 1.6 MHz.
// RULE_02: normal mode turns the high side on at each oscillator tick.
// RULE_03: ramp trip turns high side off, low side on until cycle end.
// RULE_04: eight consecutive zero-crossing cycles enter skip mode; negative current allowed meanwhile.
// RULE_05: a cycle without zero crossing clears the consecutive counter.
// RULE_06: skip pulses start on the tick; skip comparator ends the high side.
// RULE_07: output-high in skip mode: high side off now, drain, then idle.
// RULE_08: idle skip restarts at next tick once output is back to nominal.
// RULE_09: output-low flag leaves skip mode for normal operation.
// RULE_10: mode-select low forces fixed-rate operation, never skip mode.
// RULE_11: overcurrent trip ends the high-side pulse within that cycle.
// RULE_12: while the short detector trips, oscillator runs at one third rate.
// RULE_13: reset output low until about 1 ms after output is in window.
// RULE_14: reset input high drops reset output; same delay after it falls.
// RULE_15: the system ties the reset input low when unused.
// RULE_16: low supply lockout holds regulator off with both switches off.
// RULE_17: soft start drives a rising reference ramp to both loops.
// RULE_18: mode-select high allows automatic skip mode at light load.
// RULE_19: enable low turns both switches off and enables output discharge.
// RULE_20: after enable, wait about 600 us before soft start.
// RULE_21: over-temperature shuts down; recovery goes through fresh soft start.
// RULE_22: reset delay counts oscillator ticks, restarting when window or input drops.
// RULE_23: all comparator flags are synchronised before use.
//
// The address map and the APB slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module bpsm_ctrl #(
  parameter int OSC_DIV   = bpsm_pkg::OSC_DIV_CYC,
  parameter int POR_TICKS = bpsm_pkg::POR_TICKS,
  parameter int WAKE_TCK  = bpsm_pkg::WAKE_TICKS,
  parameter int SS_STEP   = bpsm_pkg::SS_STEP_TICKS
) (
  // clock and reset
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  // apb slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  // pins and comparator flags, asynchronous
  input  wire bpsm_pkg::bpsm_flags_t flags_in,
  // power stage drive
  output logic                      hs_on,
  output logic                      ls_on,
  output logic                      discharge_on,
  // soft start reference
  output logic      [7:0]           ss_ref,
  // delayed power-good, active low reset
  output logic                      reset_out_n,
  // mode status
  output logic                      pulse_skipping
);
  localparam int OCW = $clog2(bpsm_pkg::SHORT_SLOW_DIV * OSC_DIV + 1);
  localparam int WCW = $clog2(WAKE_TCK + 1);
  localparam int SCW = $clog2(SS_STEP + 1);

  generate
    if (OSC_DIV < 2 || WAKE_TCK < 1 || SS_STEP < 1) begin : g_chk
      $error("bpsm_ctrl parameters out of range");
    end
  endgenerate

  bpsm_pkg::bpsm_flags_t  f;
  bpsm_pkg::bpsm_state_t  state_r;
  bpsm_pkg::bpsm_state_t  state_nxt;
  logic [OCW-1:0]         osc_cnt_r;
  logic                   tick_r;
  logic [WCW-1:0]         wake_cnt_r;
  logic [SCW-1:0]         ss_cnt_r;
  logic [3:0]             zc_cnt_r;
  logic                   zc_seen_r;
  logic                   zc_hit;
  logic                   drain_r;
  logic                   idle_r;
  logic                   skip_en_r;
  logic                   run_ok;
  logic                   switching;
  logic                   por_done;
  logic                   apb_acc;

  function automatic logic [OCW-1:0] osc_last(input logic slow);
    osc_last = slow ? OCW'(bpsm_pkg::SHORT_SLOW_DIV * OSC_DIV - 1) : OCW'(OSC_DIV - 1);
  endfunction

  // RULE_23: two-flop sync of flags
  bpsm_sync #(
    .W (bpsm_pkg::FLAGS_W)
  ) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (flags_in),
    .sync_out (f)
  );

  // RULE_16: lockout gates operation
  // RULE_21: over-temperature gates operation
  assign run_ok    = f.enable && !f.low_supply_lockout && !f.over_temp;
  assign switching = (state_r == bpsm_pkg::ST_SOFT) || (state_r == bpsm_pkg::ST_RUN);
  assign apb_acc   = psel && penable && pready;
  assign zc_hit    = zc_seen_r || (ls_on && f.zero_cross);

  // RULE_01: oscillator divider
  // RULE_12: one third rate on short
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_cnt_r <= '0;
      tick_r    <= 1'b0;
    end else if (!run_ok) begin
      osc_cnt_r <= '0;
      tick_r    <= 1'b0;
    end else if (osc_cnt_r >= osc_last(f.output_short_detector)) begin
      osc_cnt_r <= '0;
      tick_r    <= 1'b1;
    end else begin
      osc_cnt_r <= osc_cnt_r + OCW'(1);
      tick_r    <= 1'b0;
    end
  end

  // sequencing state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      bpsm_pkg::ST_OFF: begin
        if (run_ok) begin
          state_nxt = bpsm_pkg::ST_WAKE;
        end
      end
      bpsm_pkg::ST_WAKE: begin
        // RULE_20: reference wake-up delay
        if (tick_r && wake_cnt_r == WCW'(WAKE_TCK - 1)) begin
          state_nxt = bpsm_pkg::ST_SOFT;
        end
      end
      bpsm_pkg::ST_SOFT: begin
        if (tick_r && ss_cnt_r == SCW'(SS_STEP - 1) && ss_ref == 8'hff) begin
          state_nxt = bpsm_pkg::ST_RUN;
        end
      end
      bpsm_pkg::ST_RUN: begin
        state_nxt = bpsm_pkg::ST_RUN;
      end
      default: begin
        state_nxt = bpsm_pkg::ST_OFF;
      end
    endcase
    // RULE_19: disable wins at once
    // RULE_21: shutdown restarts sequence
    if (!run_ok) begin
      state_nxt = bpsm_pkg::ST_OFF;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= bpsm_pkg::ST_OFF;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_cnt_r <= '0;
    end else if (state_r != bpsm_pkg::ST_WAKE) begin
      wake_cnt_r <= '0;
    end else if (tick_r) begin
      wake_cnt_r <= wake_cnt_r + WCW'(1);
    end
  end

  // RULE_17: soft start reference ramp
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ss_cnt_r <= '0;
      ss_ref   <= 8'h00;
    end else if (state_r == bpsm_pkg::ST_OFF || state_r == bpsm_pkg::ST_WAKE) begin
      ss_cnt_r <= '0;
      ss_ref   <= 8'h00;
    end else if (state_r == bpsm_pkg::ST_SOFT && tick_r) begin
      if (ss_cnt_r == SCW'(SS_STEP - 1)) begin
        ss_cnt_r <= '0;
        if (ss_ref != 8'hff) begin
          ss_ref <= ss_ref + 8'h01;
        end
      end else begin
        ss_cnt_r <= ss_cnt_r + SCW'(1);
      end
    end
  end

  // zero crossing seen while low side conducts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      zc_seen_r <= 1'b0;
    end else if (!switching || tick_r) begin
      zc_seen_r <= 1'b0;
    end else if (ls_on && f.zero_cross) begin
      zc_seen_r <= 1'b1;
    end
  end

  // RULE_04: count consecutive crossing cycles
  // RULE_05: miss clears the count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      zc_cnt_r <= 4'h0;
    end else if (!switching || pulse_skipping) begin
      zc_cnt_r <= 4'h0;
    end else if (tick_r) begin
      if (!zc_hit) begin
        zc_cnt_r <= 4'h0;
      end else if (zc_cnt_r != 4'(bpsm_pkg::ZC_ENTER_CNT)) begin
        zc_cnt_r <= zc_cnt_r + 4'h1;
      end
    end
  end

  // mode selection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_skipping <= 1'b0;
    end else if (state_r != bpsm_pkg::ST_RUN || !f.skip_sel || !skip_en_r) begin
      // RULE_10: forced fixed-rate mode
      pulse_skipping <= 1'b0;
    end else if (pulse_skipping && f.out_low) begin
      // RULE_09: exit on output low
      pulse_skipping <= 1'b0;
    end else if (tick_r && zc_hit && zc_cnt_r >= 4'(bpsm_pkg::ZC_ENTER_CNT - 1)) begin
      // RULE_18: automatic entry allowed
      pulse_skipping <= 1'b1;
    end
  end

  // skip-mode drain and idle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drain_r <= 1'b0;
      idle_r  <= 1'b0;
    end else if (!pulse_skipping || !switching) begin
      drain_r <= 1'b0;
      idle_r  <= 1'b0;
    end else if (idle_r) begin
      // RULE_08: resume at tick once nominal
      if (tick_r && !f.out_high) begin
        idle_r <= 1'b0;
      end
    end else if (drain_r) begin
      if (f.zero_cross || !ls_on) begin
        drain_r <= 1'b0;
        idle_r  <= 1'b1;
      end
    end else if (f.out_high) begin
      // RULE_07: stop and drain to zero
      drain_r <= 1'b1;
    end
  end

  // high-side switch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hs_on <= 1'b0;
    end else if (!switching || state_nxt == bpsm_pkg::ST_OFF) begin
      // RULE_16: both off in lockout
      // RULE_19: off at once on disable
      hs_on <= 1'b0;
    end else if (f.overcurrent_detector) begin
      // RULE_11: overcurrent cuts pulse
      hs_on <= 1'b0;
    end else if (pulse_skipping && (f.out_high || drain_r)) begin
      // RULE_07: immediate stop
      hs_on <= 1'b0;
    end else if (tick_r) begin
      // RULE_02: pulse starts on tick
      // RULE_06: skip pulses also on tick
      hs_on <= !(pulse_skipping && idle_r && f.out_high);
    end else if (pulse_skipping ? f.skip_trip : f.ramp_trip) begin
      // RULE_03: ramp trip ends pulse
      // RULE_06: skip comparator ends pulse
      hs_on <= 1'b0;
    end
  end

  // low-side switch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ls_on <= 1'b0;
    end else if (!switching || state_nxt == bpsm_pkg::ST_OFF) begin
      ls_on <= 1'b0;
    end else if (tick_r) begin
      ls_on <= 1'b0;
    end else if (pulse_skipping && (idle_r || (ls_on && f.zero_cross))) begin
      // RULE_07: idle after current reaches zero
      ls_on <= 1'b0;
    end else if (hs_on && !ls_on) begin
      // RULE_03: low side on until cycle end
      // RULE_04: negative current allowed in normal mode
      if (f.overcurrent_detector || (pulse_skipping ? (f.skip_trip || f.out_high) : f.ramp_trip)) begin
        ls_on <= 1'b1;
      end
    end
  end

  // RULE_19: output discharge while disabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      discharge_on <= 1'b0;
    end else begin
      discharge_on <= !f.enable;
    end
  end

  // RULE_13: delayed power-good
  // RULE_14: reset input re-arms delay
  // RULE_22: count oscillator ticks
  bpsm_por_timer #(
    .TICKS (POR_TICKS)
  ) u_por (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (tick_r),
    .arm     (switching && f.output_in_window && !f.timer_restart_in),
    .done    (por_done)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reset_out_n <= 1'b0;
    end else begin
      reset_out_n <= por_done && !f.timer_restart_in;
    end
  end

  // apb answer in first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= psel && !penable;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      skip_en_r <= bpsm_pkg::CTRL_SKIP_EN_RST;
    end else if (apb_acc && pwrite && paddr == bpsm_pkg::CTRL_OFF) begin
      skip_en_r <= pwdata[bpsm_pkg::CTRL_SKIP_EN_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
      case (paddr)
        bpsm_pkg::CTRL_OFF: begin
          prdata[bpsm_pkg::CTRL_SKIP_EN_BIT] <= skip_en_r;
        end
        bpsm_pkg::STATUS_OFF: begin
          if (!pwrite) begin
            prdata[bpsm_pkg::ST_STATE_LSB +: 2]  <= state_r;
            prdata[bpsm_pkg::ST_SKIP_BIT]        <= pulse_skipping;
            prdata[bpsm_pkg::ST_IDLE_BIT]        <= idle_r;
            prdata[bpsm_pkg::ST_HS_BIT]          <= hs_on;
            prdata[bpsm_pkg::ST_LS_BIT]          <= ls_on;
            prdata[bpsm_pkg::ST_RESET_OUT_BIT]   <= reset_out_n;
            prdata[bpsm_pkg::ST_SHORT_BIT]       <= f.output_short_detector;
          end else begin
            pslverr <= 1'b1;
          end
        end
        bpsm_pkg::ZCNT_OFF: begin
          if (!pwrite) begin
            prdata[3:0] <= zc_cnt_r;
          end else begin
            pslverr <= 1'b1;
          end
        end
        default: begin
          pslverr <= 1'b1;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// File: dv/bpsm_ctrl_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module bpsm_ctrl_chk (
  // clock and reset
  input wire logic                  pclk,
  input wire logic                  presetn,
  // watched ports
  input wire bpsm_pkg::bpsm_flags_t flags_in,
  input wire logic                  hs_on,
  input wire logic                  ls_on,
  input wire logic                  discharge_on,
  input wire logic [7:0]            ss_ref,
  input wire logic                  reset_out_n,
  input wire logic                  pulse_skipping
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  hs_ls_excl_a: assert property (!(hs_on && ls_on))
    else $error("both switches on");
  off_enable_a: assert property (!flags_in.enable [*4] |=> !hs_on && !ls_on && discharge_on)
    else $error("disable left a switch on");
  lockout_off_a: assert property (flags_in.low_supply_lockout [*4] |=> !hs_on && !ls_on)
    else $error("lockout left a switch on");
  temp_off_a: assert property (flags_in.over_temp [*4] |=> !hs_on && !ls_on)
    else $error("over temperature left a switch on");
  restart_drop_a: assert property (flags_in.timer_restart_in [*3] |=> !reset_out_n)
    else $error("reset out stayed high");
  window_drop_a: assert property (!flags_in.output_in_window [*3] |-> ##[1:3] !reset_out_n)
    else $error("reset out high outside window");
  skip_sel_a: assert property ($rose(pulse_skipping) |-> $past(flags_in.skip_sel, 3))
    else $error("skip mode while forced");
  ramp_step_a: assert property ($changed(ss_ref) && ss_ref != 8'h00 |-> ss_ref - $past(ss_ref) == 8'h01)
    else $error("soft start ramp jumped");
  ocp_cut_a: assert property ($rose(flags_in.overcurrent_detector) ##2 flags_in.overcurrent_detector
                              |-> ##[1:2] !hs_on)
    else $error("overcurrent did not cut high side");
  skip_exit_a: assert property (flags_in.out_low [*4] |=> !pulse_skipping)
    else $error("skip mode kept on output low");

  cover property ($rose(pulse_skipping));
  cover property ($rose(reset_out_n));
  cover property ($fell(hs_on) ##1 ls_on);
endmodule

bind bpsm_ctrl bpsm_ctrl_chk u_chk (
  .pclk(pclk), .presetn(presetn), .flags_in(flags_in), .hs_on(hs_on), .ls_on(ls_on),
  .discharge_on(discharge_on), .ss_ref(ss_ref), .reset_out_n(reset_out_n), .pulse_skipping(pulse_skipping)
);
`default_nettype wire

// File: dv/bpsm_stage_model.sv
`timescale 1ns/1ps
`default_nettype none
module bpsm_stage_model (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // switch drive and load
  input  wire logic hs_on,
  input  wire logic ls_on,
  input  wire logic light,
  // comparator outputs
  output logic      ramp_trip,
  output logic      skip_trip,
  output logic      zero_cross
);
  logic [3:0] on_cnt_r;

  // inductor current ramp
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      on_cnt_r <= 4'h0;
    end else begin
      on_cnt_r <= hs_on ? on_cnt_r + 4'h1 : 4'h0;
    end
  end
  assign ramp_trip  = hs_on && on_cnt_r >= 4'h4;
  assign skip_trip  = hs_on && on_cnt_r >= 4'h1;
  assign zero_cross = light && ls_on;
endmodule
`default_nettype wire

// File: dv/bpsm_ctrl_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module bpsm_ctrl_tb_top;
  localparam int OSC   = 12;
  localparam int POR   = 5;
  localparam int WAKE  = 3;
  localparam int LIMIT = 20000;
  logic                  pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic                  hs_on, ls_on, discharge_on, reset_out_n, pulse_skipping;
  logic                  lt, rt, st, zc;
  logic [7:0]            paddr, ss_ref;
  logic [31:0]           pwdata, prdata, rd;
  bpsm_pkg::bpsm_flags_t fl, fin;
  int                    miscompares, checked, cyc_cnt, n, wn, k;

  always_comb begin
    fin            = fl;
    fin.ramp_trip  = rt;
    fin.skip_trip  = st;
    fin.zero_cross = zc;
  end

  bpsm_ctrl #(.OSC_DIV(OSC), .POR_TICKS(POR), .WAKE_TCK(WAKE), .SS_STEP(1)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .flags_in(fin), .hs_on(hs_on),
    .ls_on(ls_on), .discharge_on(discharge_on), .ss_ref(ss_ref), .reset_out_n(reset_out_n),
    .pulse_skipping(pulse_skipping));
  bpsm_stage_model pm (.pclk(pclk), .presetn(presetn), .hs_on(hs_on), .ls_on(ls_on), .light(lt),
    .ramp_trip(rt), .skip_trip(st), .zero_cross(zc));

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    cyc_cnt++;
    if (cyc_cnt == LIMIT) begin
      miscompares++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("miscompares %0d checked %0d", miscompares, checked);
    if (miscompares == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk1(input logic a, input logic e);
    checked++;
    if (a !== e) begin
      miscompares++;
      $display("wrong value %0t bit %b exp %b", $time, a, e);
    end
  endtask

  task automatic chkn(input int v, input int lo, input int hi);
    checked++;
    if (v < lo || v > hi) begin
      miscompares++;
      $display("wrong value %0t count %0d exp %0d..%0d", $time, v, lo, hi);
    end
  endtask

  task automatic chkw(input logic [31:0] a, input logic [31:0] e);
    checked++;
    if (a !== e) begin
      miscompares++;
      $display("wrong value %0t word %h exp %h", $time, a, e);
    end
  endtask

  task automatic cyc(input int c);
    repeat (c) @(posedge pclk);
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // edges until the next high side pulse is seen
  task automatic hsr(input int lim, output int c);
    c = 0;
    while (hs_on === 1'b1 && c < lim) begin
      @(posedge pclk);
      c++;
    end
    while (hs_on !== 1'b1 && c < lim) begin
      @(posedge pclk);
      c++;
    end
  endtask

  task automatic hsw(output int c);
    c = 0;
    while (hs_on === 1'b1 && c < 50) begin
      @(posedge pclk);
      c++;
    end
  endtask

  task automatic wait_run();
    n = 0;
    while (ss_ref !== 8'hff && n < 4000) begin
      @(posedge pclk);
      n++;
    end
    chkn(n, 250 * OSC, 261 * OSC);
  endtask

  task automatic t_reg();
    apb(1'b0, bpsm_pkg::CTRL_OFF, 32'h0000_0000);
    chkw(rd, 32'h0000_0001);
    apb(1'b1, bpsm_pkg::CTRL_OFF, 32'h0000_0000);
    apb(1'b0, bpsm_pkg::CTRL_OFF, 32'h0000_0000);
    chkw(rd, 32'h0000_0000);
    apb(1'b1, bpsm_pkg::CTRL_OFF, 32'h0000_0001);
    apb(1'b1, bpsm_pkg::STATUS_OFF, 32'h0000_00ff);
    chk1(err, 1'b1);
    apb(1'b0, 8'h0c, 32'h0000_0000);
    chk1(err, 1'b1);
    chkw(rd, 32'h0000_0000);
  endtask

  task automatic t_start();
    fl.enable <= 1'b1;
    n = 0;
    while (ss_ref === 8'h00 && n < 400) begin
      @(posedge pclk);
      n++;
    end
    chkn(n, WAKE * OSC, (WAKE + 2) * OSC + 8);
    chk1(reset_out_n, 1'b0);
    wait_run();
  endtask

  task automatic t_pwm();
    hsr(40, n);
    hsr(40, n);
    chkn(n, OSC, OSC);
    hsw(wn);
    chk1(ls_on, 1'b1);
    chkn(wn, 2, OSC - 2);
    hsr(40, n);
    chkn(n, OSC - wn, OSC - wn);
  endtask

  task automatic t_por();
    chk1(reset_out_n, 1'b1);
    apb(1'b0, bpsm_pkg::STATUS_OFF, 32'h0000_0000);
    chkw(rd & 32'h0000_00c7, 32'h0000_0042);
    fl.timer_restart_in <= 1'b1;
    cyc(4);
    chk1(reset_out_n, 1'b0);
    fl.timer_restart_in <= 1'b0;
    fl.output_in_window <= 1'b0;
    cyc(8);
    chk1(reset_out_n, 1'b0);
    fl.output_in_window <= 1'b1;
    n = 0;
    while (reset_out_n !== 1'b1 && n < 300) begin
      @(posedge pclk);
      n++;
    end
    chkn(n, (POR - 1) * OSC, (POR + 1) * OSC + 6);
  endtask

  task automatic t_skip();
    lt <= 1'b1;
    repeat (5) hsr(40, n);
    lt <= 1'b0;
    hsr(40, n);
    lt <= 1'b1;
    k = 0;
    while (pulse_skipping !== 1'b1 && k < 20) begin
      hsr(40, n);
      k++;
    end
    chkn(k, 7, 10);
    chk1(pulse_skipping, 1'b1);
    hsw(n);
    chkn(n, 1, wn - 1);
    fl.out_high <= 1'b1;
    cyc(6);
    hsr(40, n);
    chkn(n, 40, 40);
    chk1(ls_on, 1'b0);
    fl.out_high <= 1'b0;
    hsr(40, n);
    chkn(n, 3, OSC + 4);
    fl.out_low <= 1'b1;
    cyc(5);
    chk1(pulse_skipping, 1'b0);
    fl.out_low <= 1'b0;
    lt <= 1'b0;
  endtask

  task automatic t_forced();
    fl.skip_sel <= 1'b0;
    lt <= 1'b1;
    repeat (12) hsr(40, n);
    chkn(n, OSC, OSC);
    chk1(pulse_skipping, 1'b0);
    fl.skip_sel <= 1'b1;
    lt <= 1'b0;
  endtask

  task automatic t_fault();
    fl.output_short_detector <= 1'b1;
    repeat (3) hsr(200, n);
    chkn(n, 3 * OSC, 3 * OSC);
    fl.output_short_detector <= 1'b0;
    hsr(40, n);
    fl.overcurrent_detector <= 1'b1;
    hsw(n);
    chkn(n, 1, 5);
    fl.overcurrent_detector <= 1'b0;
    fl.low_supply_lockout <= 1'b1;
    cyc(6);
    chk1(hs_on | ls_on, 1'b0);
    fl.low_supply_lockout <= 1'b0;
    wait_run();
    fl.over_temp <= 1'b1;
    cyc(6);
    chk1(hs_on | ls_on, 1'b0);
    chk1(ss_ref == 8'h00, 1'b1);
    fl.over_temp <= 1'b0;
    wait_run();
    fl.enable <= 1'b0;
    cyc(6);
    chk1(hs_on | ls_on, 1'b0);
    chk1(discharge_on, 1'b1);
  endtask

  initial begin
    presetn  = 1'b0;
    psel     = 1'b0;
    penable  = 1'b0;
    pwrite   = 1'b0;
    paddr    = 8'h00;
    pwdata   = 32'h0000_0000;
    lt       = 1'b0;
    fl       = '0;
    fl.skip_sel         = 1'b1;
    fl.output_in_window = 1'b1;
    cyc(3);
    presetn <= 1'b1;
    t_reg();
    t_start();
    t_pwm();
    t_por();
    t_skip();
    t_forced();
    t_fault();
    stop_test();
  end
endmodule
`default_nettype wire
